// [rtl/sfpfe_pkg.sv]
/*
  Shared constants and types of the serial flash pin front end.
  Assumes a 19-bit byte address space and a plain register port.
*/
package sfpfe_pkg;
  // array geometry
  localparam int ADDR_W = 19;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam int PAGE_LSB = 8;
  localparam int SUBSECTOR_LSB = 12;
  localparam int SECTOR_LSB = 16;
  localparam logic [3:0] SECTOR_COUNT = 4'h8;
  localparam logic [2:0] TOP_SECTOR = 3'h7;
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [2:0] LEVEL_COMPAT = 3'h1;
  localparam logic [2:0] LEVEL_ALL = 3'h4;

  // command codes, arbitrary values
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h21;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h22;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h23;
  localparam logic [7:0] CMD_SMALL_BLOCK_ERASE = 8'h24;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h25;
  localparam logic [7:0] CMD_FULL_CHIP_ERASE = 8'h26;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h27;
  localparam logic [7:0] CMD_STATUS_READ = 8'h28;

  // byte and bit positions inside a frame
  localparam logic [2:0] IDX_OPCODE = 3'h0;
  localparam logic [2:0] IDX_STATUS_DATA = 3'h1;
  localparam logic [2:0] IDX_FIRST_DATA = 3'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // device status byte
  localparam int ST_BUSY = 0;
  localparam int ST_LEVEL_LSB = 2;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] STATUS_WRITE_MASK = 8'h9c;

  // register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_PROTECT = 4'h2;
  localparam int CTRL_NEWER = 0;
  localparam int STAT_LOST = 4;
  localparam int STAT_REFUSED = 5;

  // synchroniser order: clk, din, selectN, hwResetN, protectN, topLockN
  localparam logic [5:0] SYNC_RESET = 6'h0b;

  typedef enum logic [2:0] {
    ARR_NONE,
    ARR_ERASE_PAGE,
    ARR_ERASE_SUBSECTOR,
    ARR_ERASE_SECTOR,
    ARR_ERASE_ALL,
    ARR_PROGRAM_PAGE
  } sfpfe_arr_op_t;
endpackage

// [rtl/sfpfe_sync.sv]
/*
  Two-flop synchroniser bank for pins.
  Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module sfpfe_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sfpfe_sync_t;

  sfpfe_sync_t s_reg;
  sfpfe_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.stage1 = asyncIn;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= {RESET_VAL, RESET_VAL};
    end else if (clkEn) begin
      s_reg <= s_next;
    end
  end

  assign syncOut = s_reg.stage2;
endmodule

// [rtl/sfpfe_cycle_timer.sv]
/*
  Down counter timing one internal array cycle.
  Assumes loadCount is at least one when start pulses.
*/
`timescale 1ns/1ps
module sfpfe_cycle_timer #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic start,
  input wire logic abort,
  input wire logic [WIDTH-1:0] loadCount,
  output logic running,
  output logic done
);
  typedef struct packed {
    logic running;
    logic done;
    logic [WIDTH-1:0] count;
  } sfpfe_timer_t;

  sfpfe_timer_t t_reg;
  sfpfe_timer_t t_next;

  always_comb begin
    t_next = t_reg;
    t_next.done = 1'b0;
    if (abort) begin
      t_next.running = 1'b0;
      t_next.count = '0;
    end else if (start) begin
      t_next.running = 1'b1;
      t_next.count = loadCount;
    end else if (t_reg.running) begin
      if (t_reg.count <= WIDTH'(1)) begin
        t_next.running = 1'b0;
        t_next.done = 1'b1;
        t_next.count = '0;
      end else begin
        t_next.count = t_reg.count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      t_reg <= '0;
    end else if (clkEn) begin
      t_reg <= t_next;
    end
  end

  assign running = t_reg.running;
  assign done = t_reg.done;
endmodule

// [rtl/sfpfe_front_end.sv]
/*
  Pin front end of a page organised serial flash: serial framing,
  command decode, page buffer loading, protection and cycle sequencing.
  Assumes the array back end consumes bufWr and arrOp pulses at once,
  and that all pins are asynchronous to core_clk.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
// Functional notes
// R1: serial output changes only after a falling serial clock edge, one bit per clock.
// R2: input bits are sampled on each rising serial clock edge.
// R3: deselected device keeps its serial output undriven.
// R4: deselected device drops to standby only after internal cycles end.
// R5: select low puts the device in active power.
// R6: no instruction accepted until a select falling edge after power-up.
// R7: reset pin high means normal operation.
// R8: reset pin low holds reset state with output undriven.
// R9: reset during an internal cycle disturbs it; host should avoid it.
// R10: page write or program takes one to 256 bytes.
// R11: page write erases the page, then programs it.
// R12: eight sectors of sixteen subsectors; 256 pages per sector, 16 per subsector.
// R13: 256-byte pages; in-page offset is the low eight address bits.
// R14: page, subsector, sector and full erase each have their own command.
// R15: protection is applied in whole 64-Kbyte sectors.
// R16: newer variant writes only protect-level bits and status lock bit.
// R17: newer variant pin limits follow level bits; level 001 acts like older (here level 001 locks the top sector whatever the pin).
// R18: host uses clock mode 0 or 3 only.
// R19: older variant: low top-block lock makes top 256 pages read-only.
// R20: newer variant: low protect pin freezes the protected area setting (here only while the status lock bit is set).
// R21: deselected device ignores clock and data, restarts at next select fall.
`timescale 1ns/1ps
module sfpfe_front_end
  import sfpfe_pkg::*;
#(
  parameter int ERASE_CYCLES = 2000,
  parameter int PROGRAM_CYCLES = 400,
  parameter int TIMER_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic selectN,
  input wire logic hwResetN,
  input wire logic protectPinN,
  input wire logic topBlockLockN,
  output logic serialOut,
  output logic serialOutEn,
  output logic activePower,
  output logic standbyPower,
  output logic busy,
  output logic bufWrValid,
  output logic [7:0] bufWrAddr,
  output logic [7:0] bufWrData,
  output logic arrOpValid,
  output sfpfe_pkg::sfpfe_arr_op_t arrOpKind,
  output logic [sfpfe_pkg::ADDR_W-1:0] arrOpAddr,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData
);
  import sfpfe_pkg::*;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ERASE,
    PH_PROGRAM
  } sfpfe_phase_t;

  typedef struct packed {
    logic prevSclk;
    logic prevSelected;
    logic armed;
    logic inFrame;
    logic [2:0] bitCnt;
    logic [7:0] shiftIn;
    logic [2:0] byteIdx;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [8:0] byteCount;
    logic [7:0] statusData;
    logic [7:0] shiftOut;
    logic outActive;
    logic serialOut;
    logic serialOutEn;
    logic bufWrValid;
    logic [7:0] bufWrAddr;
    logic [7:0] bufWrData;
    logic arrOpValid;
    sfpfe_arr_op_t arrOpKind;
    logic [ADDR_W-1:0] arrOpAddr;
    sfpfe_phase_t phase;
    logic pendingProgram;
    logic [2:0] protLevel;
    logic statusLock;
    logic newVariant;
    logic dataLost;
    logic refused;
    logic activePower;
    logic standbyPower;
    logic busy;
    logic [7:0] regRdData;
  } sfpfe_state_t;

  localparam logic [TIMER_WIDTH-1:0] ERASE_LOAD = TIMER_WIDTH'(ERASE_CYCLES);
  localparam logic [TIMER_WIDTH-1:0] PROGRAM_LOAD = TIMER_WIDTH'(PROGRAM_CYCLES);

  sfpfe_state_t s_reg;
  sfpfe_state_t s_next;
  logic [5:0] pinSync;
  logic sclkS;
  logic dinS;
  logic selNS;
  logic hwRstNS;
  logic protNS;
  logic topLockNS;
  logic timerStart;
  logic timerAbort;
  logic [TIMER_WIDTH-1:0] timerLoad;
  logic timerDone;

  sfpfe_sync #(
    .WIDTH(6),
    .RESET_VAL(SYNC_RESET)
  ) pinSyncBank (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .asyncIn({serialClk, serialIn, selectN, hwResetN, protectPinN, topBlockLockN}),
    .syncOut(pinSync)
  );

  assign {sclkS, dinS, selNS, hwRstNS, protNS, topLockNS} = pinSync;

  sfpfe_cycle_timer #(
    .WIDTH(TIMER_WIDTH)
  ) cycleTimer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .start(timerStart),
    .abort(timerAbort),
    .loadCount(timerLoad),
    .running(),
    .done(timerDone)
  );

  // protected region is always the top of the array, whole sectors only
  function automatic logic sectorLocked(
    input logic [2:0] sector,
    input logic [2:0] level,
    input logic newer,
    input logic pinLow
  );
    logic [3:0] floorSector;
    logic locked;
    floorSector = SECTOR_COUNT - (4'h1 << (level - 3'h1));
    locked = 1'b0;
    if (!newer) begin
      locked = pinLow && (sector == TOP_SECTOR); // R19
    end else if (level == LEVEL_NONE) begin
      locked = 1'b0;
    end else if (level >= LEVEL_ALL) begin
      locked = 1'b1; // R15
    end else begin
      locked = ({1'b0, sector} >= floorSector); // R15
    end
    if (newer && level == LEVEL_COMPAT && pinLow && sector == TOP_SECTOR) begin
      locked = 1'b1; // R17
    end
    return locked;
  endfunction

  function automatic logic [7:0] statusByte(input sfpfe_state_t st);
    logic [7:0] b;
    b = 8'h00;
    b[ST_BUSY] = st.phase != PH_IDLE;
    b[ST_LEVEL_LSB +: 3] = st.protLevel;
    b[ST_LOCK] = st.statusLock;
    return b;
  endfunction

  always_comb begin
    logic selFall;
    logic selRise;
    logic sclkRise;
    logic sclkFall;
    logic [7:0] rxByte;
    logic [2:0] sector;
    logic lockedHere;
    logic wholeBytes;
    logic idle;
    s_next = s_reg;
    selFall = selNS == 1'b0 && !s_reg.prevSelected;
    selRise = selNS && s_reg.prevSelected;
    sclkRise = sclkS && !s_reg.prevSclk; // R18
    sclkFall = !sclkS && s_reg.prevSclk;
    rxByte = {s_reg.shiftIn[6:0], dinS};
    sector = s_reg.addr[SECTOR_LSB +: 3];
    lockedHere = sectorLocked(sector, s_reg.protLevel, s_reg.newVariant, !topLockNS);
    wholeBytes = s_reg.bitCnt == 3'h0;
    idle = s_reg.phase == PH_IDLE;
    timerStart = 1'b0;
    timerAbort = 1'b0;
    timerLoad = ERASE_LOAD;
    s_next.prevSclk = sclkS;
    s_next.prevSelected = !selNS;
    s_next.bufWrValid = 1'b0;
    s_next.arrOpValid = 1'b0;
    // write one to clear; sets further down win a same-cycle clash
    if (regWr && regAddr == REG_STATUS) begin
      if (regWrData[STAT_LOST]) begin
        s_next.dataLost = 1'b0;
      end
      if (regWrData[STAT_REFUSED]) begin
        s_next.refused = 1'b0;
      end
    end

    if (!hwRstNS) begin
      // pin reset aborts everything; nonvolatile protect bits survive
      if (!idle) begin
        s_next.dataLost = 1'b1; // R9
      end
      timerAbort = 1'b1;
      s_next.phase = PH_IDLE; // R8
      s_next.pendingProgram = 1'b0;
      s_next.armed = 1'b0;
      s_next.inFrame = 1'b0;
      s_next.outActive = 1'b0;
      s_next.serialOutEn = 1'b0; // R8
      s_next.serialOut = 1'b0;
    end else begin // R7
      if (selFall) begin
        s_next.armed = 1'b1; // R6
        s_next.inFrame = 1'b1; // R5
        s_next.bitCnt = 3'h0;
        s_next.byteIdx = IDX_OPCODE;
        s_next.byteCount = 9'h000;
        s_next.addr = '0;
        s_next.outActive = 1'b0;
      end
      if (selNS) begin
        s_next.inFrame = 1'b0; // R21
        s_next.outActive = 1'b0;
        s_next.serialOutEn = 1'b0; // R3
      end

      if (s_reg.inFrame && !selNS && sclkRise) begin
        s_next.shiftIn = rxByte; // R2
        s_next.bitCnt = s_reg.bitCnt + 3'h1;
        if (s_reg.bitCnt == LAST_BIT) begin
          if (s_reg.byteIdx < IDX_FIRST_DATA) begin
            s_next.byteIdx = s_reg.byteIdx + 3'h1;
          end
          if (s_reg.byteIdx == IDX_OPCODE) begin
            s_next.opcode = rxByte;
            if (rxByte == CMD_STATUS_READ) begin
              s_next.shiftOut = statusByte(s_reg);
              s_next.outActive = 1'b1;
            end
          end else if (s_reg.opcode == CMD_STATUS_WRITE) begin
            if (s_reg.byteIdx == IDX_STATUS_DATA) begin
              s_next.statusData = rxByte;
            end
          end else if (s_reg.byteIdx < IDX_FIRST_DATA) begin
            s_next.addr = {s_reg.addr[ADDR_W-9:0], rxByte};
          end else if (idle && (s_reg.opcode == CMD_PAGE_WRITE ||
                                s_reg.opcode == CMD_PAGE_PROGRAM)) begin
            // offset wraps inside the page; bytes past 256 overwrite
            s_next.bufWrValid = 1'b1;
            s_next.bufWrAddr = s_reg.addr[7:0] + s_reg.byteCount[7:0]; // R13
            s_next.bufWrData = rxByte;
            if (s_reg.byteCount != PAGE_BYTES) begin
              s_next.byteCount = s_reg.byteCount + 9'h001; // R10
            end
          end
        end
      end

      if (s_reg.inFrame && !selNS && sclkFall && s_reg.outActive) begin
        // status repeats while the clock keeps running
        s_next.serialOut = s_reg.shiftOut[7]; // R1
        s_next.shiftOut = {s_reg.shiftOut[6:0], s_reg.shiftOut[7]}; // R1
        s_next.serialOutEn = 1'b1;
      end

      if (selRise && s_reg.inFrame && wholeBytes) begin
        s_next.arrOpAddr = {s_reg.addr[ADDR_W-1:PAGE_LSB], 8'h00}; // R13
        if (!idle && s_reg.opcode != CMD_STATUS_READ) begin
          s_next.refused = 1'b1;
        end else if ((s_reg.opcode == CMD_PAGE_WRITE ||
                      s_reg.opcode == CMD_PAGE_PROGRAM) &&
                     s_reg.byteIdx == IDX_FIRST_DATA) begin
          if (s_reg.byteCount == 9'h000 || lockedHere) begin
            s_next.refused = 1'b1; // R10
          end else if (s_reg.opcode == CMD_PAGE_WRITE) begin
            s_next.phase = PH_ERASE; // R11
            s_next.pendingProgram = 1'b1; // R11
            s_next.arrOpValid = 1'b1;
            s_next.arrOpKind = ARR_ERASE_PAGE;
            timerStart = 1'b1;
            timerLoad = ERASE_LOAD;
          end else begin
            s_next.phase = PH_PROGRAM;
            s_next.arrOpValid = 1'b1;
            s_next.arrOpKind = ARR_PROGRAM_PAGE;
            timerStart = 1'b1;
            timerLoad = PROGRAM_LOAD;
          end
        end else if ((s_reg.opcode == CMD_PAGE_ERASE ||
                      s_reg.opcode == CMD_SMALL_BLOCK_ERASE ||
                      s_reg.opcode == CMD_SECTOR_ERASE) &&
                     s_reg.byteIdx == IDX_FIRST_DATA) begin
          if (lockedHere || (!s_reg.newVariant &&
                             s_reg.opcode == CMD_SMALL_BLOCK_ERASE)) begin
            s_next.refused = 1'b1;
          end else begin
            s_next.phase = PH_ERASE; // R14
            s_next.arrOpValid = 1'b1;
            timerStart = 1'b1;
            timerLoad = ERASE_LOAD;
            unique case (s_reg.opcode)
              CMD_PAGE_ERASE: begin
                s_next.arrOpKind = ARR_ERASE_PAGE;
                s_next.arrOpAddr = {s_reg.addr[ADDR_W-1:PAGE_LSB], 8'h00}; // R12
              end
              CMD_SMALL_BLOCK_ERASE: begin
                s_next.arrOpKind = ARR_ERASE_SUBSECTOR;
                s_next.arrOpAddr = {s_reg.addr[ADDR_W-1:SUBSECTOR_LSB], 12'h000}; // R12
              end
              default: begin
                s_next.arrOpKind = ARR_ERASE_SECTOR;
                s_next.arrOpAddr = {s_reg.addr[ADDR_W-1:SECTOR_LSB], 16'h0000}; // R12
              end
            endcase
          end
        end else if (s_reg.opcode == CMD_FULL_CHIP_ERASE &&
                     s_reg.byteIdx == IDX_STATUS_DATA) begin
          // top sector is inside every protected region
          if (!s_reg.newVariant ||
              sectorLocked(TOP_SECTOR, s_reg.protLevel, 1'b1, !topLockNS)) begin
            s_next.refused = 1'b1;
          end else begin
            s_next.phase = PH_ERASE; // R14
            s_next.arrOpValid = 1'b1;
            s_next.arrOpKind = ARR_ERASE_ALL;
            s_next.arrOpAddr = '0;
            timerStart = 1'b1;
            timerLoad = ERASE_LOAD;
          end
        end else if (s_reg.opcode == CMD_STATUS_WRITE &&
                     s_reg.byteIdx == IDX_FIRST_DATA - 3'h2) begin
          if (!s_reg.newVariant || (s_reg.statusLock && !protNS)) begin
            s_next.refused = 1'b1; // R20
          end else begin
            s_next.protLevel = s_reg.statusData[ST_LEVEL_LSB +: 3]; // R16
            s_next.statusLock = s_reg.statusData[ST_LOCK]; // R16
          end
        end
      end

      if (timerDone) begin
        if (s_reg.phase == PH_ERASE && s_reg.pendingProgram) begin
          s_next.phase = PH_PROGRAM; // R11
          s_next.pendingProgram = 1'b0;
          s_next.arrOpValid = 1'b1;
          s_next.arrOpKind = ARR_PROGRAM_PAGE;
          timerStart = 1'b1;
          timerLoad = PROGRAM_LOAD;
        end else begin
          s_next.phase = PH_IDLE;
        end
      end
    end

    // standby only once deselected and no array cycle remains
    s_next.activePower = !selNS || s_next.phase != PH_IDLE; // R5
    s_next.standbyPower = selNS && s_next.phase == PH_IDLE; // R4
    s_next.busy = s_next.phase != PH_IDLE;

    if (regWr && regAddr == REG_CTRL) begin
      s_next.newVariant = regWrData[CTRL_NEWER];
    end
    s_next.regRdData = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        REG_CTRL: s_next.regRdData = {7'h00, s_reg.newVariant};
        REG_STATUS: s_next.regRdData = {2'h0, s_reg.refused, s_reg.dataLost,
                                        s_reg.armed, s_reg.standbyPower,
                                        s_reg.inFrame, s_reg.busy};
        REG_PROTECT: s_next.regRdData = statusByte(s_reg);
        default: s_next.regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else if (clkEn) begin
      s_reg <= s_next;
    end
  end

  assign serialOut = s_reg.serialOut;
  assign serialOutEn = s_reg.serialOutEn;
  assign activePower = s_reg.activePower;
  assign standbyPower = s_reg.standbyPower;
  assign busy = s_reg.busy;
  assign bufWrValid = s_reg.bufWrValid;
  assign bufWrAddr = s_reg.bufWrAddr;
  assign bufWrData = s_reg.bufWrData;
  assign arrOpValid = s_reg.arrOpValid;
  assign arrOpKind = s_reg.arrOpKind;
  assign arrOpAddr = s_reg.arrOpAddr;
  assign regRdData = s_reg.regRdData;
endmodule

// [tb/sfpfe_props.sv]
/*
  Port checker for sfpfe_front_end.
  Bound from the testbench; sees only the top module's ports.
*/
`timescale 1ns/1ps
module sfpfe_props (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic serialClk,
  input wire logic selectN,
  input wire logic hwResetN,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic activePower,
  input wire logic standbyPower,
  input wire logic busy,
  input wire logic bufWrValid,
  input wire logic arrOpValid,
  input wire sfpfe_pkg::sfpfe_arr_op_t arrOpKind,
  input wire logic [sfpfe_pkg::ADDR_W-1:0] arrOpAddr
);
  import sfpfe_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // six cycles cover the two sync flops plus the output register
  a_desel_hiz: assert property (selectN [*6] |-> !serialOutEn)
    else $error("output driven while deselected");
  a_reset_hiz: assert property ((!hwResetN) [*6] |-> !serialOutEn)
    else $error("output driven during pin reset");
  a_select_active: assert property ((!selectN && hwResetN) [*6] |-> activePower)
    else $error("selected but not active");
  a_standby_idle: assert property (standbyPower |-> !busy && !activePower)
    else $error("standby during cycle or selection");
  // clock low lasts four core cycles, longer than the sync delay
  a_out_fall: assert property (serialOutEn && $past(serialOutEn) && $changed(serialOut)
    |-> !serialClk)
    else $error("output moved while serial clock high");
  a_sub_align: assert property (arrOpValid && arrOpKind == ARR_ERASE_SUBSECTOR
    |-> arrOpAddr[11:0] == 12'h000)
    else $error("subsector erase not aligned");
  a_sect_align: assert property (arrOpValid && arrOpKind == ARR_ERASE_SECTOR
    |-> arrOpAddr[15:0] == 16'h0000)
    else $error("sector erase not aligned");
  a_op_busy: assert property (arrOpValid |=> busy)
    else $error("array op without busy");
  a_desel_quiet: assert property (selectN [*6] |-> !bufWrValid)
    else $error("buffer write while deselected");
endmodule

// [tb/sfpfe_spi_host.sv]
/*
  Behavioural bus master for the serial flash pins.
  Assumes 800 ns serial clock, mode 0 or 3 chosen by idleHigh.
*/
`timescale 1ns/1ps
module sfpfe_spi_host (
  output logic serialClk,
  output logic serialIn,
  output logic selectN,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  logic idleHigh;
  initial begin
    idleHigh = 1'b0;
    serialClk = 1'b0;
    serialIn = 1'b0;
    selectN = 1'b1;
  end
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx);
    logic [7:0] r;
    serialClk = idleHigh;
    // odd offset keeps pin edges off the core clock edges
    #437 selectN = 1'b0;
    #400;
    foreach (tx[i]) begin
      for (int b = 7; b >= 0; b--) begin
        serialClk = 1'b0;
        serialIn = tx[i][b];
        #400 serialClk = 1'b1;
        r[b] = serialOutEn ? serialOut : 1'bx;
        #400;
      end
    end
    serialClk = idleHigh;
    // released data line must not look held
    serialIn = ~serialIn;
    #400 selectN = 1'b1;
    #1600;
    rx = r;
  endtask
endmodule

// [tb/testbench.sv]
/*
  Self-checking bench for sfpfe_front_end.
  Assumes sfpfe_spi_host as far side and sfpfe_props bound below.
*/
`timescale 1ns/1ps
module testbench;
  import sfpfe_pkg::*;
  logic core_clk, reset_n, clkEn, hwResetN, protectPinN, topBlockLockN;
  logic serialClk, serialIn, selectN, serialOut, serialOutEn;
  logic activePower, standbyPower, busy, bufWrValid, arrOpValid, regWr, regRd;
  logic [7:0] bufWrAddr, bufWrData, regWrData, regRdData, rx, d;
  logic [3:0] regAddr;
  sfpfe_arr_op_t arrOpKind;
  logic [ADDR_W-1:0] arrOpAddr;
  logic [21:0] opQ[$];
  logic [15:0] wrQ[$];
  logic [7:0] q[$];
  int err_count = 0;
  int checks_done = 0;

  sfpfe_front_end #(.ERASE_CYCLES(5), .PROGRAM_CYCLES(3)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .serialClk(serialClk),
    .serialIn(serialIn), .selectN(selectN), .hwResetN(hwResetN),
    .protectPinN(protectPinN), .topBlockLockN(topBlockLockN), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .activePower(activePower), .standbyPower(standbyPower),
    .busy(busy), .bufWrValid(bufWrValid), .bufWrAddr(bufWrAddr), .bufWrData(bufWrData),
    .arrOpValid(arrOpValid), .arrOpKind(arrOpKind), .arrOpAddr(arrOpAddr),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData));
  sfpfe_spi_host host (.serialClk(serialClk), .serialIn(serialIn), .selectN(selectN),
    .serialOut(serialOut), .serialOutEn(serialOutEn));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (arrOpValid === 1'b1) opQ.push_back({arrOpKind, arrOpAddr});
    if (bufWrValid === 1'b1) wrQ.push_back({bufWrAddr, bufWrData});
  end

  function automatic logic [21:0] pop_op();
    return opQ.size() ? opQ.pop_front() : 'x;
  endfunction
  function automatic logic [15:0] pop_wr();
    return wrQ.size() ? wrQ.pop_front() : 'x;
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk) v = regRdData;
  endtask
  // busy stays high from erase into program; wait for four quiet cycles in a row
  task automatic wait_idle();
    int low = 0;
    for (int n = 0; n < 300 && low < 4; n++) begin
      @(posedge core_clk);
      low = (busy === 1'b0) ? low + 1 : 0;
    end
    if (low < 4) begin
      err_count++;
      $display("[FAIL] %0t busy never cleared", $time);
      end_sim();
    end
  endtask
  task automatic frame_idle(input logic [7:0] tx[$]);
    host.frame(tx, rx);
    wait_idle();
  endtask

  task automatic t_status();
    reg_wr(REG_CTRL, 8'h01);
    frame_idle('{CMD_STATUS_WRITE, 8'hff});
    reg_rd(REG_PROTECT, d);
    chk(d, 8'h9c);
    protectPinN <= 1'b0;
    frame_idle('{CMD_STATUS_WRITE, 8'h00});
    reg_rd(REG_PROTECT, d);
    chk(d, 8'h9c);
    protectPinN <= 1'b1;
    q = '{CMD_STATUS_READ, 8'h00, 8'h00};
    host.frame(q, rx);
    chk(rx, 8'h9c);
    frame_idle('{CMD_STATUS_WRITE, 8'h00});
    reg_rd(4'hf, d);
    chk(d, 8'h00);
    $display("status test done");
  endtask
  task automatic t_program();
    reg_wr(REG_CTRL, 8'h00);
    frame_idle('{CMD_PAGE_PROGRAM, 8'h01, 8'h02, 8'hfe, 8'ha5, 8'h5a, 8'h3c});
    chk(pop_op(), {ARR_PROGRAM_PAGE, 19'h10200});
    chk(pop_wr(), 16'hfea5);
    chk(pop_wr(), 16'hff5a);
    chk(pop_wr(), 16'h003c);
    chk(standbyPower, 1'b1);
    frame_idle('{CMD_PAGE_WRITE, 8'h00, 8'h03, 8'h10, 8'h77});
    chk(pop_op(), {ARR_ERASE_PAGE, 19'h00300});
    chk(pop_op(), {ARR_PROGRAM_PAGE, 19'h00300});
    chk(pop_wr(), 16'h1077);
    $display("program test done");
  endtask
  task automatic t_erase();
    logic [7:0] c[3];
    logic [21:0] e[3];
    c = '{CMD_PAGE_ERASE, CMD_SMALL_BLOCK_ERASE, CMD_SECTOR_ERASE};
    e = '{{ARR_ERASE_PAGE, 19'h12300}, {ARR_ERASE_SUBSECTOR, 19'h12000},
      {ARR_ERASE_SECTOR, 19'h10000}};
    host.idleHigh = 1'b1;
    reg_wr(REG_CTRL, 8'h01);
    for (int i = 0; i < 3; i++) begin
      frame_idle('{c[i], 8'h01, 8'h23, 8'h45});
      chk(pop_op(), e[i]);
    end
    frame_idle('{CMD_FULL_CHIP_ERASE});
    chk(pop_op(), {ARR_ERASE_ALL, 19'h0});
    host.idleHigh = 1'b0;
    $display("erase test done");
  endtask
  task automatic t_protect();
    reg_wr(REG_CTRL, 8'h00);
    topBlockLockN <= 1'b0;
    frame_idle('{CMD_SECTOR_ERASE, 8'h07, 8'h00, 8'h00});
    chk(opQ.size(), 0);
    reg_rd(REG_STATUS, d);
    chk(d[STAT_REFUSED], 1'b1);
    frame_idle('{CMD_SECTOR_ERASE, 8'h06, 8'hff, 8'hff});
    chk(pop_op(), {ARR_ERASE_SECTOR, 19'h60000});
    topBlockLockN <= 1'b1;
    $display("protect test done");
  endtask
  task automatic t_hwreset();
    hwResetN <= 1'b0;
    repeat (5) @(posedge core_clk);
    frame_idle('{CMD_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h11});
    chk(opQ.size() + wrQ.size(), 0);
    hwResetN <= 1'b1;
    repeat (5) @(posedge core_clk);
    frame_idle('{CMD_PAGE_PROGRAM, 8'h00, 8'h00, 8'h00, 8'h11});
    chk(pop_op(), {ARR_PROGRAM_PAGE, 19'h0});
    chk(pop_wr(), 16'h0011);
    $display("pin reset test done");
  endtask

  initial begin
    clkEn = 1'b1;
    hwResetN = 1'b1;
    protectPinN = 1'b1;
    topBlockLockN = 1'b1;
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    t_status();
    t_program();
    t_erase();
    t_protect();
    t_hwreset();
    end_sim();
  end
endmodule

bind sfpfe_front_end sfpfe_props chk_i (.core_clk(core_clk), .reset_n(reset_n),
  .serialClk(serialClk), .selectN(selectN), .hwResetN(hwResetN), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .activePower(activePower), .standbyPower(standbyPower),
  .busy(busy), .bufWrValid(bufWrValid), .arrOpValid(arrOpValid), .arrOpKind(arrOpKind),
  .arrOpAddr(arrOpAddr));
